// ### mqs_top.sv
// Write and read port queue switch sequencing with per-port flag selection
// What this block does
// - Write strobe high captures write queue address
// - Write enable ignored for selection, used for mark
// - Switch takes four cycles, one per four
// - Any queue may follow any queue
// - Present queue keeps writing during switch
// - Ports switch independently, same or different queues
// - Write QS-1 starts switch, records rewrite choice
// - QS0 applies mark or un-mark to next
// - Standard mode QS2: almost-full, packet, full flags
// - Fall-through QS2: packet and input-ready flags
// - Writes to next queue start at QS3
// - Read strobe high captures read queue address
// - Read enable ignored for selection, used for mark
// - Present queue keeps reading during switch
// - Read QS-1 starts switch, records re-read choice
// - QS2: almost-empty, packet, standard empty flags
// - Unmarked self switch without mark is ignored
// - Unmarked self switch with mark adds mark
// - Marked self switch needs re-read; mark follows request
// - Write and read marks are independent
// - One mark per port; resume mark or last
// - Enable at QS-1 keeps present pointer advancing
// - Enable idle at QS-1 freezes present pointer
`timescale 1ns/100ps
`default_nettype none
module mqs_top #(
   parameter int NUM_QUEUES = mqs_pkg::MQS_MAX_QUEUES
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Mode
   input wire logic first_word_fall_through_mode_i,
   // Write port request
   input wire logic wr_addr_strobe_i,
   input wire logic [mqs_pkg::MQS_QW-1:0] wr_queue_addr_i,
   input wire logic wr_en_i,
   // Write port per-queue status
   input wire logic [NUM_QUEUES-1:0] wr_full_i,
   input wire logic [NUM_QUEUES-1:0] wr_almost_full_i,
   input wire logic [NUM_QUEUES-1:0] wr_packet_ready_i,
   input wire logic [NUM_QUEUES-1:0] wr_input_ready_i,
   // Write port answer
   output logic [mqs_pkg::MQS_QW-1:0] wr_present_queue_o,
   output logic wr_access_o,
   output logic wr_restart_o,
   output logic wr_busy_o,
   output logic wr_mark_valid_o,
   output logic [mqs_pkg::MQS_QW-1:0] wr_mark_queue_o,
   output logic full_flag_o,
   output logic almost_full_flag_o,
   output logic wr_packet_ready_flag_o,
   output logic input_ready_flag_o,
   // Read port request
   input wire logic rd_addr_strobe_i,
   input wire logic [mqs_pkg::MQS_QW-1:0] rd_queue_addr_i,
   input wire logic rd_en_i,
   // Read port per-queue status
   input wire logic [NUM_QUEUES-1:0] rd_empty_i,
   input wire logic [NUM_QUEUES-1:0] rd_almost_empty_i,
   input wire logic [NUM_QUEUES-1:0] rd_packet_ready_i,
   input wire logic [NUM_QUEUES-1:0] rd_output_ready_i,
   // Read port answer
   output logic [mqs_pkg::MQS_QW-1:0] rd_present_queue_o,
   output logic rd_access_o,
   output logic rd_restart_o,
   output logic rd_busy_o,
   output logic rd_mark_valid_o,
   output logic [mqs_pkg::MQS_QW-1:0] rd_mark_queue_o,
   output logic empty_flag_o,
   output logic almost_empty_flag_o,
   output logic rd_packet_ready_flag_o,
   output logic output_ready_flag_o
);
   import mqs_pkg::*;

   generate
      if (NUM_QUEUES < 1 || NUM_QUEUES > MQS_MAX_QUEUES) begin : g_bad_count
         $error("mqs_top: queue count must be 1 to 8");
      end
   endgenerate

   mqs_port_if #(.QW(MQS_QW)) wr_if ();
   mqs_port_if #(.QW(MQS_QW)) rd_if ();

   // Separate sequencers: each port switches on its own, even together
   mqs_port_seq #(.NUM_QUEUES(NUM_QUEUES)) u_wr_seq (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .port_if(wr_if)
   );

   mqs_port_seq #(.NUM_QUEUES(NUM_QUEUES)) u_rd_seq (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .port_if(rd_if)
   );

   assign wr_if.strobe = wr_addr_strobe_i;
   assign wr_if.addr = wr_queue_addr_i;
   assign wr_if.en = wr_en_i;
   assign rd_if.strobe = rd_addr_strobe_i;
   assign rd_if.addr = rd_queue_addr_i;
   assign rd_if.en = rd_en_i;

   function automatic logic pick(input logic [NUM_QUEUES-1:0] vec,
                                 input logic [MQS_QW-1:0] q);
      pick = vec[q];
   endfunction

   logic fall_through;
   logic full_flag, next_full_flag;
   logic almost_full_flag, next_almost_full_flag;
   logic wr_packet_ready_flag, next_wr_packet_ready_flag;
   logic input_ready_flag, next_input_ready_flag;
   logic empty_flag, next_empty_flag;
   logic almost_empty_flag, next_almost_empty_flag;
   logic rd_packet_ready_flag, next_rd_packet_ready_flag;
   logic output_ready_flag, next_output_ready_flag;

   assign fall_through = first_word_fall_through_mode_i;

   // Flags follow the queue one edge ahead so the registered copy
   // shows the next queue exactly in the stated switch cycle
   always_comb begin
      next_wr_packet_ready_flag = pick(wr_packet_ready_i,
                                       wr_if.flag_ahead);
      if (fall_through) begin
         next_full_flag = 1'b0;
         next_almost_full_flag = 1'b0;
         next_input_ready_flag = pick(wr_input_ready_i,
                                      wr_if.flag_ahead);
      end else begin
         next_full_flag = pick(wr_full_i, wr_if.flag_ahead);
         next_almost_full_flag = pick(wr_almost_full_i,
                                      wr_if.flag_ahead);
         next_input_ready_flag = 1'b0;
      end
   end

   always_comb begin
      next_almost_empty_flag = pick(rd_almost_empty_i,
                                    rd_if.flag_ahead);
      next_rd_packet_ready_flag = pick(rd_packet_ready_i,
                                       rd_if.flag_ahead);
      if (fall_through) begin
         next_empty_flag = 1'b0;
         next_output_ready_flag = pick(rd_output_ready_i,
                                       rd_if.present_ahead);
      end else begin
         next_empty_flag = pick(rd_empty_i, rd_if.flag_ahead);
         next_output_ready_flag = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         full_flag <= MQS_RST_FLAG;
         almost_full_flag <= MQS_RST_FLAG;
         wr_packet_ready_flag <= MQS_RST_FLAG;
         input_ready_flag <= MQS_RST_FLAG;
         empty_flag <= MQS_RST_FLAG;
         almost_empty_flag <= MQS_RST_FLAG;
         rd_packet_ready_flag <= MQS_RST_FLAG;
         output_ready_flag <= MQS_RST_FLAG;
      end else begin
         full_flag <= next_full_flag;
         almost_full_flag <= next_almost_full_flag;
         wr_packet_ready_flag <= next_wr_packet_ready_flag;
         input_ready_flag <= next_input_ready_flag;
         empty_flag <= next_empty_flag;
         almost_empty_flag <= next_almost_empty_flag;
         rd_packet_ready_flag <= next_rd_packet_ready_flag;
         output_ready_flag <= next_output_ready_flag;
      end
   end

   assign full_flag_o = full_flag;
   assign almost_full_flag_o = almost_full_flag;
   assign wr_packet_ready_flag_o = wr_packet_ready_flag;
   assign input_ready_flag_o = input_ready_flag;
   assign empty_flag_o = empty_flag;
   assign almost_empty_flag_o = almost_empty_flag;
   assign rd_packet_ready_flag_o = rd_packet_ready_flag;
   assign output_ready_flag_o = output_ready_flag;

   assign wr_present_queue_o = wr_if.present_queue;
   assign wr_access_o = wr_if.access;
   assign wr_restart_o = wr_if.restart;
   assign wr_busy_o = wr_if.busy;
   assign wr_mark_valid_o = wr_if.mark_valid;
   assign wr_mark_queue_o = wr_if.mark_queue;
   assign rd_present_queue_o = rd_if.present_queue;
   assign rd_access_o = rd_if.access;
   assign rd_restart_o = rd_if.restart;
   assign rd_busy_o = rd_if.busy;
   assign rd_mark_valid_o = rd_if.mark_valid;
   assign rd_mark_queue_o = rd_if.mark_queue;
endmodule
`default_nettype wire

// ### mqs_pkg.sv
// Shared constants and types of the multi-queue switch sequencer
package mqs_pkg;
   localparam int MQS_MAX_QUEUES = 8;
   localparam int MQS_QW = 3;
   localparam int MQS_SWITCH_CYCLES = 4;
   localparam logic [MQS_QW-1:0] MQS_RST_QUEUE = 3'h0;
   localparam logic MQS_RST_FLAG = 1'b0;
   typedef enum logic [1:0] {
      MQS_ST_IDLE,
      MQS_ST_QS0,
      MQS_ST_QS1,
      MQS_ST_QS2
   } mqs_state_t;
endpackage

// ### mqs_port_if.sv
// Link between the top and one port's switch sequencer
`timescale 1ns/100ps
`default_nettype none
interface mqs_port_if #(
   parameter int QW = mqs_pkg::MQS_QW
);
   logic strobe;
   logic [QW-1:0] addr;
   logic en;
   logic [QW-1:0] present_queue;
   logic [QW-1:0] present_ahead;
   logic [QW-1:0] flag_ahead;
   logic [QW-1:0] mark_queue;
   logic mark_valid;
   logic access;
   logic restart;
   logic busy;
   modport seq (
      input strobe, addr, en,
      output present_queue, present_ahead, flag_ahead, mark_queue,
      output mark_valid, access, restart, busy
   );
   modport user (
      output strobe, addr, en,
      input present_queue, present_ahead, flag_ahead, mark_queue,
      input mark_valid, access, restart, busy
   );
endinterface
`default_nettype wire

// ### mqs_port_seq.sv
// Four-cycle queue switch sequencer for one port, with mark handling
`timescale 1ns/100ps
`default_nettype none
module mqs_port_seq #(
   parameter int NUM_QUEUES = mqs_pkg::MQS_MAX_QUEUES
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Port link
   mqs_port_if.seq port_if
);
   import mqs_pkg::*;

   localparam logic [MQS_QW:0] NUM_QUEUES_L = (MQS_QW+1)'(NUM_QUEUES);

   mqs_state_t state, next_state;
   logic [MQS_QW-1:0] present_queue, next_present_queue;
   logic [MQS_QW-1:0] next_queue, next_next_queue;
   logic [MQS_QW-1:0] flag_queue, next_flag_queue;
   logic [MQS_QW-1:0] mark_queue, next_mark_queue;
   logic mark_valid, next_mark_valid;
   logic freeze, next_freeze;
   logic restart_pend, next_restart_pend;
   logic restart, next_restart;
   logic addr_ok;
   logic same;

   assign addr_ok = {1'b0, port_if.addr} < NUM_QUEUES_L;
   assign same = next_queue == present_queue;

   always_comb begin
      next_state = state;
      next_present_queue = present_queue;
      next_next_queue = next_queue;
      next_flag_queue = flag_queue;
      next_mark_queue = mark_queue;
      next_mark_valid = mark_valid;
      next_freeze = freeze;
      next_restart_pend = restart_pend;
      next_restart = 1'b0;
      case (state)
         MQS_ST_IDLE: begin
            // Strobes while busy start no switch: one switch per 4 cycles
            if (port_if.strobe && addr_ok) begin
               next_state = MQS_ST_QS0;
               next_next_queue = port_if.addr;
               next_freeze = ~port_if.en;
            end
         end
         MQS_ST_QS0: begin
            next_state = MQS_ST_QS1;
            next_restart_pend = freeze && same && mark_valid;
            // Strobe level in this cycle is the mark request
            if (same) begin
               if (!mark_valid) begin
                  if (port_if.strobe) begin
                     next_mark_valid = 1'b1;
                     next_mark_queue = present_queue;
                  end else begin
                     next_freeze = 1'b0;
                  end
               end else if (freeze) begin
                  next_mark_valid = port_if.strobe;
               end
            end else begin
               // One mark per port, on the queue that becomes active
               next_mark_valid = port_if.strobe;
               next_mark_queue = next_queue;
            end
         end
         MQS_ST_QS1: begin
            next_state = MQS_ST_QS2;
            next_flag_queue = next_queue;
         end
         MQS_ST_QS2: begin
            next_state = MQS_ST_IDLE;
            next_present_queue = next_queue;
            next_restart = restart_pend;
            next_freeze = 1'b0;
         end
         default: begin
            next_state = MQS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= MQS_ST_IDLE;
         present_queue <= MQS_RST_QUEUE;
         next_queue <= MQS_RST_QUEUE;
         flag_queue <= MQS_RST_QUEUE;
         mark_queue <= MQS_RST_QUEUE;
         mark_valid <= MQS_RST_FLAG;
         freeze <= MQS_RST_FLAG;
         restart_pend <= MQS_RST_FLAG;
         restart <= MQS_RST_FLAG;
      end else begin
         state <= next_state;
         present_queue <= next_present_queue;
         next_queue <= next_next_queue;
         flag_queue <= next_flag_queue;
         mark_queue <= next_mark_queue;
         mark_valid <= next_mark_valid;
         freeze <= next_freeze;
         restart_pend <= next_restart_pend;
         restart <= next_restart;
      end
   end

   assign port_if.busy = state != MQS_ST_IDLE;
   // Present queue keeps its access through the switch unless frozen
   assign port_if.access = port_if.en && !(port_if.busy && freeze);
   assign port_if.present_queue = present_queue;
   assign port_if.present_ahead = (state == MQS_ST_QS2) ? next_queue :
                                  present_queue;
   assign port_if.flag_ahead = (state == MQS_ST_QS1) ? next_queue :
                               flag_queue;
   assign port_if.mark_queue = mark_queue;
   assign port_if.mark_valid = mark_valid;
   assign port_if.restart = restart;
endmodule
`default_nettype wire

// ### mqs_top_assertions.sv
// Port-level timing checks for the queue switch sequencer
`timescale 1ns/100ps
`default_nettype none
module mqs_top_assertions #(
   parameter int NUM_QUEUES = mqs_pkg::MQS_MAX_QUEUES
) (
   // Clock, reset and mode
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic first_word_fall_through_mode_i,
   // Write port
   input wire logic wr_addr_strobe_i,
   input wire logic [mqs_pkg::MQS_QW-1:0] wr_queue_addr_i,
   input wire logic wr_en_i,
   input wire logic [mqs_pkg::MQS_QW-1:0] wr_present_queue_o,
   input wire logic wr_access_o,
   input wire logic wr_busy_o,
   input wire logic wr_mark_valid_o,
   input wire logic [mqs_pkg::MQS_QW-1:0] wr_mark_queue_o,
   // Read port
   input wire logic rd_addr_strobe_i,
   input wire logic [mqs_pkg::MQS_QW-1:0] rd_queue_addr_i,
   input wire logic rd_en_i,
   input wire logic [NUM_QUEUES-1:0] rd_empty_i,
   input wire logic [NUM_QUEUES-1:0] rd_output_ready_i,
   input wire logic [mqs_pkg::MQS_QW-1:0] rd_present_queue_o,
   input wire logic rd_busy_o,
   input wire logic rd_restart_o,
   input wire logic rd_mark_valid_o,
   input wire logic empty_flag_o,
   input wire logic output_ready_flag_o
);
   import mqs_pkg::*;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic wr_go = !wr_busy_o && wr_addr_strobe_i;
   wire logic rd_go = !rd_busy_o && rd_addr_strobe_i;
   chk_wr_busy_span: assert property ($rose(wr_busy_o) |->
      wr_busy_o [*3] ##1 !wr_busy_o) else $error("busy span wrong");
   chk_wr_take: assert property (wr_go |=> wr_busy_o)
      else $error("write switch not taken");
   chk_wr_present: assert property ($fell(wr_busy_o) |->
      wr_present_queue_o == $past(wr_queue_addr_i, 4))
      else $error("write queue not the requested one");
   chk_wr_hold: assert property (wr_busy_o |->
      $stable(wr_present_queue_o)) else $error("queue moved early");
   chk_wr_freeze: assert property (wr_go && !wr_en_i &&
      wr_queue_addr_i != wr_present_queue_o |=> !wr_access_o [*3]
      ##1 wr_access_o == wr_en_i) else $error("freeze wrong");
   chk_wr_mark_add: assert property (wr_go ##1 wr_addr_strobe_i |=>
      wr_mark_valid_o && wr_mark_queue_o == $past(wr_queue_addr_i, 2))
      else $error("mark not applied");
   chk_rd_unmark: assert property (rd_go && (!rd_en_i ||
      rd_queue_addr_i != rd_present_queue_o) ##1 !rd_addr_strobe_i
      |=> !rd_mark_valid_o) else $error("mark not removed");
   chk_rd_restart: assert property (rd_restart_o |-> $past(rd_busy_o)
      && !rd_busy_o && $past(rd_mark_valid_o, 4))
      else $error("restart out of place");
   chk_rd_empty: assert property (rd_go &&
      !first_word_fall_through_mode_i ##3 1 |->
      empty_flag_o == rd_empty_i[$past(rd_queue_addr_i, 3)])
      else $error("empty flag not for next queue");
   chk_rd_out_ready: assert property (rd_go &&
      first_word_fall_through_mode_i ##4 1 |->
      output_ready_flag_o == rd_output_ready_i[$past(rd_queue_addr_i, 4)])
      else $error("output ready not for next queue");
   cover property (wr_go ##1 wr_addr_strobe_i);
   cover property (rd_restart_o);
   cover property (wr_go && rd_go);
endmodule
bind mqs_top mqs_top_assertions #(.NUM_QUEUES(NUM_QUEUES))
   mqs_top_assertions_inst (
   .core_clk_i, .rst_n_i, .first_word_fall_through_mode_i,
   .wr_addr_strobe_i, .wr_queue_addr_i, .wr_en_i, .wr_present_queue_o,
   .wr_access_o, .wr_busy_o, .wr_mark_valid_o, .wr_mark_queue_o,
   .rd_addr_strobe_i, .rd_queue_addr_i, .rd_en_i, .rd_empty_i,
   .rd_output_ready_i, .rd_present_queue_o, .rd_busy_o, .rd_restart_o,
   .rd_mark_valid_o, .empty_flag_o, .output_ready_flag_o);
`default_nettype wire

// ### mqs_host_model.sv
// Host logic of one port: queue select, mark request and enable
`timescale 1ns/100ps
`default_nettype none
module mqs_host_model (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Commands
   input wire logic go_i,
   input wire logic [mqs_pkg::MQS_QW-1:0] queue_i,
   input wire logic mark_i,
   input wire logic en_i,
   // Port pins
   output logic strobe_o,
   output logic [mqs_pkg::MQS_QW-1:0] addr_o,
   output logic en_o
);
   import mqs_pkg::*;
   logic [1:0] gap;
   assign en_o = en_i;
   // Address is not held outside the strobe, so it toggles
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap <= 2'h0;
         strobe_o <= 1'b0;
         addr_o <= MQS_RST_QUEUE;
      end else if (gap == 2'h0) begin
         strobe_o <= go_i;
         addr_o <= go_i ? queue_i : ~addr_o;
         gap <= go_i ? 2'h3 : 2'h0;
      end else begin
         strobe_o <= (gap == 2'h3) & mark_i;
         addr_o <= ~addr_o;
         gap <= gap - 2'h1;
      end
   end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the queue switch sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import mqs_pkg::*;
   typedef struct packed {
      logic [2:0] wq;
      logic [2:0] rq;
      logic en;
      logic mk;
      logic fw;
      logic mv;
   } mqs_row_t;
   logic clk, rst_n, go, en, mk, fw, pmv, wstb, rstb, wen, ren;
   logic [2:0] wq, rq, wa, ra, wpq, wmq, rpq, rmq;
   logic wacc, wrs, wbsy, wmv, fullf, aff, wpf, irf;
   logic racc, rrs, rbsy, rmv, emptyf, aef, rpf, orf;
   logic [63:0] st;
   int n_mismatch, checked;
   // No row switches a marked queue to itself without re-read
   mqs_row_t rows [12] = '{
      '{3'h3, 3'h5, 1'h1, 1'h0, 1'h0, 1'h0},
      '{3'h6, 3'h6, 1'h1, 1'h1, 1'h0, 1'h1},
      '{3'h1, 3'h2, 1'h0, 1'h0, 1'h1, 1'h0},
      '{3'h1, 3'h2, 1'h1, 1'h1, 1'h1, 1'h1},
      '{3'h1, 3'h2, 1'h0, 1'h1, 1'h0, 1'h1},
      '{3'h1, 3'h2, 1'h0, 1'h0, 1'h0, 1'h0},
      '{3'h1, 3'h2, 1'h1, 1'h0, 1'h0, 1'h0},
      '{3'h0, 3'h7, 1'h1, 1'h1, 1'h1, 1'h1},
      '{3'h7, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0},
      '{3'h2, 3'h1, 1'h1, 1'h0, 1'h1, 1'h0},
      '{3'h5, 3'h3, 1'h1, 1'h1, 1'h0, 1'h1},
      '{3'h4, 3'h4, 1'h0, 1'h0, 1'h1, 1'h0}};
   mqs_host_model wr_host (.core_clk_i(clk), .rst_n_i(rst_n), .go_i(go),
      .queue_i(wq), .mark_i(mk), .en_i(en), .strobe_o(wstb), .addr_o(wa),
      .en_o(wen));
   mqs_host_model rd_host (.core_clk_i(clk), .rst_n_i(rst_n), .go_i(go),
      .queue_i(rq), .mark_i(mk), .en_i(en), .strobe_o(rstb), .addr_o(ra),
      .en_o(ren));
   mqs_top #(.NUM_QUEUES(MQS_MAX_QUEUES)) mqs_top_inst (
      .core_clk_i(clk), .rst_n_i(rst_n), .first_word_fall_through_mode_i(fw),
      .wr_addr_strobe_i(wstb), .wr_queue_addr_i(wa), .wr_en_i(wen),
      .wr_full_i(st[7:0]), .wr_almost_full_i(st[15:8]),
      .wr_packet_ready_i(st[23:16]), .wr_input_ready_i(st[31:24]),
      .wr_present_queue_o(wpq), .wr_access_o(wacc), .wr_restart_o(wrs),
      .wr_busy_o(wbsy), .wr_mark_valid_o(wmv), .wr_mark_queue_o(wmq),
      .full_flag_o(fullf), .almost_full_flag_o(aff),
      .wr_packet_ready_flag_o(wpf), .input_ready_flag_o(irf),
      .rd_addr_strobe_i(rstb), .rd_queue_addr_i(ra), .rd_en_i(ren),
      .rd_empty_i(st[39:32]), .rd_almost_empty_i(st[47:40]),
      .rd_packet_ready_i(st[55:48]), .rd_output_ready_i(st[63:56]),
      .rd_present_queue_o(rpq), .rd_access_o(racc), .rd_restart_o(rrs),
      .rd_busy_o(rbsy), .rd_mark_valid_o(rmv), .rd_mark_queue_o(rmq),
      .empty_flag_o(emptyf), .almost_empty_flag_o(aef),
      .rd_packet_ready_flag_o(rpf), .output_ready_flag_o(orf));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic summarize;
      if (n_mismatch == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cmpq(input logic [2:0] got, input logic [2:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmpf(input logic got, input logic exp);
      cmpq({2'h0, got}, {2'h0, exp});
   endtask
   task automatic wait_busy(input logic lvl);
      for (int i = 0; i < 9 && wbsy !== lvl; i++) begin
         @(posedge clk);
         #1;
      end
      if (wbsy !== lvl) begin
         n_mismatch++;
         summarize();
      end
   endtask
   task automatic run(input mqs_row_t r);
      logic xw, xr;
      xw = pmv && !r.en && r.wq == wpq;
      xr = pmv && !r.en && r.rq == rpq;
      @(posedge clk);
      {go, wq, rq, en, mk, fw} <= {1'b1, r.wq, r.rq, r.en, r.mk, r.fw};
      st <= {st[62:0], st[63]};
      @(posedge clk);
      go <= 1'b0;
      wait_busy(1'b1);
      cmpf(rbsy, 1'b1);
      wait_busy(1'b0);
      cmpf(wrs, xw);
      cmpf(rrs, xr);
      cmpq(wpq, r.wq);
      cmpq(rpq, r.rq);
      cmpf(wmv, r.mv);
      cmpf(rmv, r.mv);
      if (r.mv) begin
         cmpq(wmq, r.wq);
         cmpq(rmq, r.rq);
      end
      cmpf(fullf, !r.fw & st[r.wq]);
      cmpf(aff, !r.fw & st[8+r.wq]);
      cmpf(wpf, st[16+r.wq]);
      cmpf(irf, r.fw & st[24+r.wq]);
      cmpf(emptyf, !r.fw & st[32+r.rq]);
      cmpf(aef, st[40+r.rq]);
      cmpf(rpf, st[48+r.rq]);
      cmpf(orf, r.fw & st[56+r.rq]);
      pmv = r.mv;
   endtask
   initial begin
      {rst_n, go, en, mk, fw, pmv, wq, rq} = '0;
      st = 64'hA53C_965A_C369_0FE1;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[k]) run(rows[k]);
      // Freeze chosen, enable raised afterwards, then back-to-back
      @(posedge clk);
      {go, wq, en} <= {1'b1, 3'h6, 1'b0};
      @(posedge clk);
      wq <= 3'h2;
      @(posedge clk);
      en <= 1'b1;
      #1;
      cmpf(wacc, 1'b0);
      cmpf(racc, 1'b0);
      repeat (3) @(posedge clk);
      go <= 1'b0;
      #1;
      cmpq(wpq, 3'h6);
      cmpf(wacc, 1'b1);
      wait_busy(1'b1);
      wait_busy(1'b0);
      cmpq(wpq, 3'h2);
      // Reset in the middle of a marking switch on both ports
      @(posedge clk);
      {go, mk} <= 2'h3;
      repeat (3) @(posedge clk);
      go <= 1'b0;
      #1;
      cmpf(wbsy, 1'b1);
      cmpf(rmv, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      #1;
      cmpf(wbsy, 1'b0);
      cmpq(wpq, MQS_RST_QUEUE);
      cmpf(rmv, MQS_RST_FLAG);
      // Two edges in reset so a cut switch never looks like a busy fall
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      pmv = 1'b0;
      run(rows[0]);
      summarize();
   end
endmodule
`default_nettype wire
